// ### shared/seq_pkg.sv
package seq_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int MEM_CYCLE_NS = 4000;
    // Memory cycle in clocks, least time so rounded up
    localparam int MEM_CLKS = (MEM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] MEM_LAST = 7'(MEM_CLKS - 1);

    // ****************************************************************
    // Word and field layout
    // ****************************************************************
    typedef logic [25:1] word_t;
    typedef logic [14:0] addr_t;
    localparam int IND_BIT = 25;
    localparam int X_HI = 24;
    localparam int X_LO = 21;
    localparam int OP_HI = 20;
    localparam int OP_LO = 15;
    localparam int GRP_HI = 14;
    localparam int GRP_LO = 11;
    localparam int M_HI = 10;
    localparam int M_LO = 1;
    // Control word address portion and descriptor fields
    localparam int CA_HI = 15;
    localparam int CA_LO = 1;
    localparam int FS_HI = 20;
    localparam int FS_LO = 18;
    localparam int LB_HI = 20;
    localparam int LB_LO = 16;

    // ****************************************************************
    // Codes and reset values
    // ****************************************************************
    localparam logic [5:0] OP_STORE = 6'h08;
    localparam logic [5:0] OP_STORE_NEG = 6'h09;
    localparam logic [1:0] NEXT_PLUS1 = 2'h0;
    localparam logic [1:0] NEXT_PLUS2 = 2'h1;
    localparam logic [1:0] NEXT_JUMP = 2'h2;
    localparam addr_t COUNTER_RESET = 15'h0000;
    localparam addr_t ADDR_ONE = 15'h0001;
    localparam addr_t ADDR_TWO = 15'h0002;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic rd;
        logic wr;
        word_t wdata;
    } mem_req_s;

    typedef struct packed {
        logic valid;
        logic field_sel;
        word_t data;
    } operand_s;

    typedef struct packed {
        logic valid;
        logic [5:0] op;
    } func_s;

endpackage : seq_pkg

// ### hw/operand_address_sequencer.sv
`timescale 1ns/1ps

module operand_address_sequencer (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic run,
    output seq_pkg::addr_t mem_addr,
    output seq_pkg::mem_req_s mem_req,
    input wire seq_pkg::word_t mem_rdata,
    output logic [3:0] index_sel,
    input wire seq_pkg::addr_t index_val,
    output logic [3:0] accumulator_group_select,
    output logic [1:0] acc_sel,
    input wire seq_pkg::word_t acc_rdata,
    output seq_pkg::operand_s operand,
    output seq_pkg::func_s func,
    input wire logic [1:0] next_sel,
    output seq_pkg::addr_t instruction_address,
    output logic instr_done,
    output logic [7:0] instr_cycles
);

    // ****************************************************************
    // Types and helpers
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_ADDR,
        ST_CW_FETCH,
        ST_CW_ADDR,
        ST_XSTART,
        ST_XFER
    } state_e;

    // Highest designated accumulator below limit, limit 4 means any
    function automatic logic [1:0] top_below(input logic [3:0] mask, input logic [2:0] lim);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 0; i < 4; i++)
        begin
            if (mask[i] && (3'(i) < lim))
            begin
                r = 2'(i);
            end
        end
        return r;
    endfunction : top_below

    // Any designated accumulator below the given one
    function automatic logic any_below(input logic [3:0] mask, input logic [1:0] idx);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            if (mask[i] && (2'(i) < idx))
            begin
                r = 1'b1;
            end
        end
        return r;
    endfunction : any_below

    state_e state_reg;
    logic [6:0] cyc_cnt_reg;
    logic [7:0] mem_cycles_reg;
    seq_pkg::addr_t instruction_address_counter_reg;
    seq_pkg::addr_t access_address_holder_reg;
    seq_pkg::addr_t jump_reg;
    seq_pkg::word_t instr_reg;
    seq_pkg::word_t cw_reg;
    logic fext_reg;
    logic [4:0] fext_bound_reg;
    logic [1:0] acc_sel_reg;
    logic [3:0] index_sel_reg;
    logic [3:0] group_reg;
    // ****************************************************************
    // Decode of the current access
    // ****************************************************************
    logic access;
    logic mem_end;
    logic is_store;
    logic last_word;
    seq_pkg::addr_t nia;
    seq_pkg::addr_t eff;
    seq_pkg::word_t fmask;

    always_comb
    begin
        access = (state_reg == ST_FETCH) || (state_reg == ST_CW_FETCH) ||
                 (state_reg == ST_XFER);
        mem_end = access && (cyc_cnt_reg == seq_pkg::MEM_LAST);
        is_store = (instr_reg[seq_pkg::OP_HI:seq_pkg::OP_LO] == seq_pkg::OP_STORE) ||
                   (instr_reg[seq_pkg::OP_HI:seq_pkg::OP_LO] == seq_pkg::OP_STORE_NEG);
        last_word = !any_below(group_reg, acc_sel_reg);
    end

    // Address adder: effective address sums and next instruction address
    always_comb
    begin
        if (state_reg == ST_CW_ADDR)
        begin
            eff = index_val + cw_reg[seq_pkg::CA_HI:seq_pkg::CA_LO];
        end
        else
        begin
            // Ten bit displacement zero-padded to fifteen bits for the index sum
            eff = index_val + {5'h00, instr_reg[seq_pkg::M_HI:seq_pkg::M_LO]};
        end
        unique case (next_sel)
            seq_pkg::NEXT_PLUS2: nia = instruction_address_counter_reg + seq_pkg::ADDR_TWO;
            seq_pkg::NEXT_JUMP: nia = jump_reg;
            default: nia = instruction_address_counter_reg + seq_pkg::ADDR_ONE;
        endcase
    end

    // Field mask keeps bits from 1 up to the descriptor bound
    always_comb
    begin
        for (int b = 1; b <= 25; b++)
        begin
            fmask[b] = (5'(b) <= fext_bound_reg);
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // Phase sequencing through fetch, address, chain and transfer
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= ST_IDLE;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE: if (run) state_reg <= ST_FETCH;
                ST_FETCH: if (mem_end) state_reg <= ST_ADDR;
                ST_ADDR:
                begin
                    if (instr_reg[seq_pkg::IND_BIT])
                    begin
                        state_reg <= ST_CW_FETCH;
                    end
                    else
                    begin
                        state_reg <= ST_XSTART;
                    end
                end
                ST_CW_FETCH: if (mem_end) state_reg <= ST_CW_ADDR;
                ST_CW_ADDR:
                begin
                    if (cw_reg[seq_pkg::IND_BIT])
                    begin
                        state_reg <= ST_CW_FETCH;
                    end
                    else
                    begin
                        state_reg <= ST_XSTART;
                    end
                end
                ST_XSTART: state_reg <= ST_XFER;
                ST_XFER:
                begin
                    if (mem_end)
                    begin
                        if (!last_word)
                        begin
                            state_reg <= ST_XSTART;
                        end
                        else if (run)
                        begin
                            state_reg <= ST_FETCH;
                        end
                        else
                        begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Memory cycle timer, one full cycle per access
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cyc_cnt_reg <= 7'h00;
        end
        else if (!access || mem_end)
        begin
            cyc_cnt_reg <= 7'h00;
        end
        else
        begin
            cyc_cnt_reg <= cyc_cnt_reg + 7'h01;
        end
    end

    // ****************************************************************
    // Address registers
    // ****************************************************************
    // Instruction counter, access holder and jump target
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            instruction_address_counter_reg <= seq_pkg::COUNTER_RESET;
            access_address_holder_reg <= seq_pkg::COUNTER_RESET;
            jump_reg <= seq_pkg::COUNTER_RESET;
        end
        else if (state_reg == ST_ADDR || state_reg == ST_CW_ADDR)
        begin
            access_address_holder_reg <= eff;
            jump_reg <= eff;
        end
        else if (state_reg == ST_XFER && mem_end)
        begin
            if (!last_word)
            begin
                // Step down to next operand word
                access_address_holder_reg <= access_address_holder_reg - seq_pkg::ADDR_ONE;
            end
            else
            begin
                // Next address formed only on the last word transfer
                instruction_address_counter_reg <= nia;
                access_address_holder_reg <= nia;
            end
        end
    end

    // ****************************************************************
    // Working register and selects
    // ****************************************************************
    // Instruction and control word capture with select decode
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            instr_reg <= '0;
            cw_reg <= '0;
            index_sel_reg <= 4'h0;
            group_reg <= 4'h0;
        end
        else if (state_reg == ST_FETCH && mem_end)
        begin
            instr_reg <= mem_rdata;
            index_sel_reg <= mem_rdata[seq_pkg::X_HI:seq_pkg::X_LO];
            group_reg <= mem_rdata[seq_pkg::GRP_HI:seq_pkg::GRP_LO];
        end
        else if (state_reg == ST_CW_FETCH && mem_end)
        begin
            cw_reg <= mem_rdata;
            index_sel_reg <= mem_rdata[seq_pkg::X_HI:seq_pkg::X_LO];
        end
    end

    // Field selection decision on a terminal control word
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fext_reg <= 1'b0;
            fext_bound_reg <= 5'h00;
        end
        else if (state_reg == ST_ADDR)
        begin
            fext_reg <= 1'b0;
        end
        else if (state_reg == ST_CW_ADDR && !cw_reg[seq_pkg::IND_BIT])
        begin
            // Nonzero bits 18-20 mark a descriptor, zero a final pointer
            fext_reg <= |cw_reg[seq_pkg::FS_HI:seq_pkg::FS_LO];
            fext_bound_reg <= cw_reg[seq_pkg::LB_HI:seq_pkg::LB_LO];
        end
    end

    // Accumulator walk from highest designated downward
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            acc_sel_reg <= 2'h0;
        end
        else if (state_reg == ST_ADDR)
        begin
            acc_sel_reg <= top_below(group_reg, 3'h4);
        end
        else if (state_reg == ST_XFER && mem_end && !last_word)
        begin
            acc_sel_reg <= top_below(group_reg, {1'b0, acc_sel_reg});
        end
    end

    // ****************************************************************
    // Memory, operand and function outputs
    // ****************************************************************
    seq_pkg::mem_req_s mem_req_reg;
    seq_pkg::operand_s operand_reg;
    seq_pkg::func_s func_reg;
    logic instr_done_reg;
    logic [7:0] instr_cycles_reg;

    // Memory strobes held for the whole memory cycle
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mem_req_reg <= '0;
        end
        else if (state_reg == ST_XSTART)
        begin
            mem_req_reg.rd <= !is_store;
            mem_req_reg.wr <= is_store;
            mem_req_reg.wdata <= acc_rdata;
        end
        else if ((state_reg == ST_IDLE && run) || (state_reg == ST_ADDR &&
                 instr_reg[seq_pkg::IND_BIT]) || (state_reg == ST_CW_ADDR &&
                 cw_reg[seq_pkg::IND_BIT]) || (state_reg == ST_XFER && mem_end &&
                 last_word && run))
        begin
            mem_req_reg.rd <= 1'b1;
            mem_req_reg.wr <= 1'b0;
        end
        else if (mem_end)
        begin
            mem_req_reg.rd <= 1'b0;
            mem_req_reg.wr <= 1'b0;
        end
    end

    // Operand word to the arithmetic unit, masked under field selection
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            operand_reg <= '0;
        end
        else if (state_reg == ST_XFER && mem_end && !is_store)
        begin
            operand_reg.valid <= 1'b1;
            operand_reg.field_sel <= fext_reg;
            operand_reg.data <= fext_reg ? (mem_rdata & fmask) : mem_rdata;
        end
        else
        begin
            operand_reg.valid <= 1'b0;
        end
    end

    // Function signals pulse while the address sum is formed
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            func_reg <= '0;
        end
        else
        begin
            // Valid exactly in the address phase, clear of any memory cycle
            func_reg.valid <= (state_reg == ST_FETCH) && mem_end;
            if ((state_reg == ST_FETCH) && mem_end)
            begin
                func_reg.op <= mem_rdata[seq_pkg::OP_HI:seq_pkg::OP_LO];
            end
        end
    end

    // Execution time in memory cycles per instruction
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mem_cycles_reg <= 8'h00;
            instr_cycles_reg <= 8'h00;
            instr_done_reg <= 1'b0;
        end
        else
        begin
            instr_done_reg <= 1'b0;
            if (mem_end && state_reg == ST_XFER && last_word)
            begin
                instr_cycles_reg <= mem_cycles_reg + 8'h01;
                instr_done_reg <= 1'b1;
                mem_cycles_reg <= 8'h00;
            end
            else if (mem_end)
            begin
                mem_cycles_reg <= mem_cycles_reg + 8'h01;
            end
        end
    end

    // ****************************************************************
    // Output drive
    // ****************************************************************
    assign mem_addr = access_address_holder_reg;
    assign mem_req = mem_req_reg;
    assign index_sel = index_sel_reg;
    assign accumulator_group_select = group_reg;
    assign acc_sel = acc_sel_reg;
    assign operand = operand_reg;
    assign func = func_reg;
    assign instruction_address = instruction_address_counter_reg;
    assign instr_done = instr_done_reg;
    assign instr_cycles = instr_cycles_reg;

endmodule : operand_address_sequencer

// ### dv/op_seq_monitor.sv
`timescale 1ns/1ps

// ****************************************************************
// Port checker
// ****************************************************************
module op_seq_monitor (
    input wire logic core_clk,
    input wire logic nrst,
    input wire seq_pkg::addr_t mem_addr,
    input wire seq_pkg::mem_req_s mem_req,
    input wire logic [1:0] acc_sel,
    input wire seq_pkg::word_t acc_rdata,
    input wire seq_pkg::operand_s operand,
    input wire seq_pkg::func_s func,
    input wire logic [1:0] next_sel,
    input wire seq_pkg::addr_t instruction_address,
    input wire logic instr_done
);
    logic [7:0] busy_cnt;
    logic busy_q;
    seq_pkg::addr_t addr_q;
    logic busy;
    logic restart;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // Back to back cycles keep the strobe up; a new address starts one
    assign busy = mem_req.rd || mem_req.wr;
    assign restart = busy && busy_q && (mem_addr != addr_q);

    // Clocks spent in the current memory cycle
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            busy_cnt <= 8'h00;
            busy_q <= 1'b0;
            addr_q <= '0;
        end
        else
        begin
            busy_q <= busy;
            addr_q <= mem_addr;
            if (!busy)
                busy_cnt <= 8'h00;
            else if (restart)
                busy_cnt <= 8'h01;
            else
                busy_cnt <= busy_cnt + 8'h01;
        end
    end

    property p_mem_len;
        ($fell(busy) || restart) |-> busy_cnt == 8'(seq_pkg::MEM_CLKS);
    endproperty
    a_mem_len: assert property (p_mem_len) else $error("memory cycle length wrong");
    property p_mem_max;
        (busy && !restart) |-> busy_cnt < 8'(seq_pkg::MEM_CLKS);
    endproperty
    a_mem_max: assert property (p_mem_max) else $error("memory cycle too long");
    property p_func_phase;
        func.valid |-> !mem_req.rd && !mem_req.wr;
    endproperty
    a_func_phase: assert property (p_func_phase) else $error("function outside address phase");
    property p_done_addr;
        instr_done |-> mem_addr == instruction_address;
    endproperty
    a_done_addr: assert property (p_done_addr) else $error("holders disagree at end");
    property p_next_one;
        instr_done && ($past(next_sel) == seq_pkg::NEXT_PLUS1 || $past(next_sel) == 2'h3)
            |-> instruction_address == $past(instruction_address) + seq_pkg::ADDR_ONE;
    endproperty
    a_next_one: assert property (p_next_one) else $error("step by one wrong");
    property p_next_two;
        instr_done && $past(next_sel) == seq_pkg::NEXT_PLUS2
            |-> instruction_address == $past(instruction_address) + seq_pkg::ADDR_TWO;
    endproperty
    a_next_two: assert property (p_next_two) else $error("step by two wrong");
    property p_cc_hold;
        !instr_done |-> $stable(instruction_address);
    endproperty
    a_cc_hold: assert property (p_cc_hold) else $error("counter moved mid instruction");
    property p_store_quiet;
        mem_req.wr |-> !operand.valid && !mem_req.rd;
    endproperty
    a_store_quiet: assert property (p_store_quiet) else $error("operand during store");
    property p_wr_data;
        mem_req.wr |-> mem_req.wdata == acc_rdata;
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("store data not accumulator");
    property p_wr_hold;
        mem_req.wr && $past(mem_req.wr) |-> $stable(mem_addr) && $stable(acc_sel);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("store pairing moved");

    c_store: cover property ($rose(mem_req.wr));
    c_field: cover property (operand.valid && operand.field_sel);
    c_jump: cover property (instr_done && $past(next_sel) == seq_pkg::NEXT_JUMP);
endmodule : op_seq_monitor

bind operand_address_sequencer op_seq_monitor mon (
    .core_clk(core_clk), .nrst(nrst), .mem_addr(mem_addr), .mem_req(mem_req),
    .acc_sel(acc_sel), .acc_rdata(acc_rdata), .operand(operand), .func(func),
    .next_sel(next_sel), .instruction_address(instruction_address), .instr_done(instr_done));

// ### dv/core_memory_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Core memory, index and accumulator model
// ****************************************************************
module core_memory_model (
    input wire logic core_clk,
    input wire seq_pkg::addr_t mem_addr,
    input wire seq_pkg::mem_req_s mem_req,
    output seq_pkg::word_t mem_rdata,
    input wire logic [3:0] index_sel,
    output seq_pkg::addr_t index_val,
    input wire logic [1:0] acc_sel,
    output seq_pkg::word_t acc_rdata
);
    seq_pkg::word_t mem [0:511];
    seq_pkg::addr_t xreg [0:15];
    seq_pkg::word_t acc [0:3];
    logic flip = 1'b0;

    // Store writes the word while the cycle runs
    always @(posedge core_clk)
    begin
        flip <= ~flip;
        if (mem_req.wr)
            mem[mem_addr[8:0]] <= mem_req.wdata;
    end

    // Read data only during a read cycle, a changing pattern otherwise
    assign mem_rdata = mem_req.rd ? mem[mem_addr[8:0]] : ({25{flip}} ^ 25'h0aaaaaa);
    assign index_val = xreg[index_sel];
    assign acc_rdata = acc[acc_sel];
endmodule : core_memory_model

// ### dv/operand_address_sequencer_tb_top.sv
`timescale 1ns/1ps

`define CHECK(got, exp, msg) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("CHECK FAILED %0t %s", $time, msg); \
        end \
    end

module operand_address_sequencer_tb_top;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic run = 1'b0;
    logic [1:0] next_sel = 2'h0;
    seq_pkg::addr_t mem_addr;
    seq_pkg::mem_req_s mem_req;
    seq_pkg::word_t mem_rdata;
    logic [3:0] index_sel;
    seq_pkg::addr_t index_val;
    logic [3:0] accumulator_group_select;
    logic [1:0] acc_sel;
    seq_pkg::word_t acc_rdata;
    seq_pkg::operand_s operand;
    seq_pkg::func_s func;
    seq_pkg::addr_t instruction_address;
    logic instr_done;
    logic [7:0] instr_cycles;
    seq_pkg::operand_s op_q [$];
    logic [5:0] last_op = 6'h00;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;

    always #25 core_clk = ~core_clk;

    operand_address_sequencer DUT (
        .core_clk(core_clk), .nrst(nrst), .run(run), .mem_addr(mem_addr), .mem_req(mem_req),
        .mem_rdata(mem_rdata), .index_sel(index_sel), .index_val(index_val),
        .accumulator_group_select(accumulator_group_select), .acc_sel(acc_sel),
        .acc_rdata(acc_rdata), .operand(operand), .func(func), .next_sel(next_sel),
        .instruction_address(instruction_address), .instr_done(instr_done),
        .instr_cycles(instr_cycles));

    core_memory_model mem_model (
        .core_clk(core_clk), .mem_addr(mem_addr), .mem_req(mem_req), .mem_rdata(mem_rdata),
        .index_sel(index_sel), .index_val(index_val), .acc_sel(acc_sel),
        .acc_rdata(acc_rdata));

    // Collect operand words and function codes
    always @(negedge core_clk)
    begin
        if (operand.valid === 1'b1)
            op_q.push_back(operand);
        if (func.valid === 1'b1)
            last_op = func.op;
    end

    // Cut a hung run short
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles >= 5000)
        begin
            miscompares++;
            $display("CHECK FAILED %0t timeout", $time);
            wrap_up();
        end
    end

    function automatic seq_pkg::word_t instr_w(logic ind, logic [3:0] x, logic [5:0] op,
                                               logic [3:0] grp, logic [9:0] m);
        return {ind, x, op, grp, m};
    endfunction : instr_w

    function automatic seq_pkg::word_t ctrl_w(logic ind, logic [3:0] x, logic [4:0] lb,
                                              seq_pkg::addr_t a);
        return {ind, x, lb, a};
    endfunction : ctrl_w

    task automatic wait_done(int exp_words);
        int n;
        n = 0;
        @(negedge core_clk);
        while (instr_done !== 1'b1 && n < 1000)
        begin
            @(negedge core_clk);
            n++;
        end
        `CHECK(n < 1000, 1'b1, "instruction end seen")
        // Let the collector take the last operand before counting
        @(negedge core_clk);
        `CHECK(op_q.size(), exp_words, "operand word count")
    endtask : wait_done

    task automatic test_direct_load();
        wait_done(1);
        `CHECK(op_q[0].data, 25'h0abcdef, "indexed operand")
        `CHECK(op_q[0].field_sel, 1'b0, "direct not field")
        `CHECK(last_op, 6'h0a, "function code")
        `CHECK(instruction_address, 15'h0001, "plus one")
        `CHECK(mem_addr, 15'h0001, "holder loaded")
        `CHECK(instr_cycles, 8'h02, "single word cycles")
        `CHECK(index_sel, 4'h1, "index select")
        `CHECK(accumulator_group_select, 4'h1, "group select")
        op_q.delete();
        next_sel = seq_pkg::NEXT_PLUS2;
        $display("test direct load finished");
    endtask : test_direct_load

    task automatic test_multi_store();
        wait_done(0);
        `CHECK(mem_model.mem[9'h020], 25'h0222222, "low word from highest")
        `CHECK(mem_model.mem[9'h01f], 25'h0111111, "next word from lower")
        `CHECK(mem_model.mem[9'h01e], 25'h0000000, "loop overrun")
        `CHECK(mem_model.mem[9'h021], 25'h0000000, "wrong direction")
        `CHECK(instruction_address, 15'h0003, "plus two")
        `CHECK(instr_cycles, 8'h03, "multiword cycles")
        `CHECK(acc_sel, 2'h1, "walk ends at lowest")
        next_sel = seq_pkg::NEXT_PLUS1;
        $display("test multiword store finished");
    endtask : test_multi_store

    task automatic test_final_pointer();
        wait_done(1);
        `CHECK(op_q[0].data, 25'h1234567, "pointer target")
        `CHECK(op_q[0].field_sel, 1'b0, "no field select")
        `CHECK(instr_cycles, 8'h03, "indirect cycles")
        `CHECK(instruction_address, 15'h0004, "after indirect")
        op_q.delete();
        next_sel = seq_pkg::NEXT_JUMP;
        run = 1'b0;
        $display("test final pointer finished");
    endtask : test_final_pointer

    task automatic test_field_jump();
        wait_done(1);
        `CHECK(op_q[0].data, 25'h000000f, "outside bits zeroed")
        `CHECK(op_q[0].field_sel, 1'b1, "descriptor seen")
        `CHECK(instr_cycles, 8'h04, "chained cycles")
        `CHECK(last_op, 6'h0c, "function code")
        `CHECK(instruction_address, 15'h0050, "jump target")
        `CHECK(mem_addr, 15'h0050, "holder at target")
        repeat (200) @(negedge core_clk);
        `CHECK(mem_req.rd, 1'b0, "stopped after run low")
        $display("test field jump finished");
    endtask : test_field_jump

    task automatic wrap_up();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    // Program, data and main sequence
    initial
    begin
        for (int i = 0; i < 512; i++)
            mem_model.mem[i] = 25'h0000000;
        mem_model.xreg = '{1: 15'h0100, 2: 15'h0010, default: 15'h0000};
        mem_model.acc = '{25'h0000011, 25'h0111111, 25'h0222222, 25'h0333333};
        mem_model.mem[0] = instr_w(1'b0, 4'h1, 6'h0a, 4'h1, 10'h005);
        mem_model.mem[1] = instr_w(1'b0, 4'h0, seq_pkg::OP_STORE, 4'h6, 10'h020);
        mem_model.mem[3] = instr_w(1'b1, 4'h0, 6'h0a, 4'h1, 10'h070);
        mem_model.mem[4] = instr_w(1'b1, 4'h0, 6'h0c, 4'h1, 10'h030);
        mem_model.mem[9'h105] = 25'h0abcdef;
        mem_model.mem[9'h070] = ctrl_w(1'b0, 4'h1, 5'h00, 15'h0008);
        mem_model.mem[9'h108] = 25'h1234567;
        mem_model.mem[9'h030] = ctrl_w(1'b1, 4'h2, 5'h00, 15'h0030);
        mem_model.mem[9'h040] = ctrl_w(1'b0, 4'h0, 5'h04, 15'h0050);
        mem_model.mem[9'h050] = 25'h1ffffff;
        repeat (4) @(negedge core_clk);
        nrst = 1'b1;
        @(negedge core_clk);
        run = 1'b1;
        test_direct_load();
        test_multi_store();
        test_final_pointer();
        test_field_jump();
        wrap_up();
    end
endmodule : operand_address_sequencer_tb_top
